//--- cdirq_pkg.sv
// Purpose: shared constants for the chain interrupt and pin setup block
// Assumes: 20 MHz reference clock, twelve chain lines and twelve pins
// Notes:   every offset, code, reset value and count used in logic lives here
package cdirq_pkg;
  localparam int NUM_LINES = 12;
  localparam int NUM_PINS  = 12;
  localparam int NUM_RTC   = 8;
  localparam int IDX_W     = 4;
  localparam int KIND_W    = 3;
  localparam int CNT_W     = 16;

  // source kinds for chain lines and pin drivers
  localparam logic [KIND_W-1:0] SRC_NONE  = 3'h0;
  localparam logic [KIND_W-1:0] SRC_RTC   = 3'h1;
  localparam logic [KIND_W-1:0] SRC_PIG   = 3'h2;
  localparam logic [KIND_W-1:0] SRC_INPUT = 3'h3;
  localparam logic [KIND_W-1:0] SRC_GPS   = 3'h4;
  localparam logic [KIND_W-1:0] SRC_IRIG  = 3'h5;
  localparam logic [KIND_W-1:0] SRC_LINE  = 3'h6;

  // configuration commands
  localparam logic [2:0] CFG_LINE_SRC  = 3'h0;
  localparam logic [2:0] CFG_LINE_MODE = 3'h1;
  localparam logic [2:0] CFG_PIN_SET   = 3'h2;
  localparam logic [2:0] CFG_PIN_SRC   = 3'h3;
  localparam logic [2:0] CFG_REFCLK    = 3'h4;

  // per-line commands
  localparam logic [2:0] CMD_ARM     = 3'h0;
  localparam logic [2:0] CMD_DISARM  = 3'h1;
  localparam logic [2:0] CMD_ENABLE  = 3'h2;
  localparam logic [2:0] CMD_DISABLE = 3'h3;
  localparam logic [2:0] CMD_REQUEST = 3'h4;

  // trigger modes
  localparam logic [1:0] MODE_RISE = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h1;
  localparam logic [1:0] MODE_HIGH = 2'h2;
  localparam logic [1:0] MODE_LOW  = 2'h3;

  // flag bit positions
  localparam int FLG_OUT  = 0;
  localparam int FLG_TERM = 1;
  localparam int FLG_EXT  = 0;

  // reset values
  localparam logic [NUM_PINS-1:0] PIN_DIR_RST = 12'h03F;

  // minimum level hold on anything we drive
  localparam int CLK_PERIOD_NS = 50;
  localparam int HOLD_NS       = 1000;
  localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W        = 5;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC - 1);
endpackage : cdirq_pkg

//--- cdirq_cnt_if.sv
// Purpose: carrier between the controller and its fire counter bank
// Assumes: single clock domain
// Notes:   inc is a per-line pulse, read answers one cycle later
`timescale 1ns/1ps
interface cdirq_cnt_if;
  logic [cdirq_pkg::NUM_LINES-1:0] inc;
  logic                            rd_en;
  logic [cdirq_pkg::IDX_W-1:0]     rd_sel;
  logic [cdirq_pkg::CNT_W-1:0]     rd_data;
  logic                            rd_valid;
  modport ctl  (output inc, output rd_en, output rd_sel, input rd_data, input rd_valid);
  modport bank (input inc, input rd_en, input rd_sel, output rd_data, output rd_valid);
endinterface : cdirq_cnt_if

//--- cdirq_cnt_bank.sv
// Purpose: per-line fire counters with a registered read port
// Assumes: rd_sel below the line count
// Notes:   counters wrap; increment and read in one cycle return the old value
`timescale 1ns/1ps
module cdirq_cnt_bank (
  // clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // controller side
  cdirq_cnt_if.bank  cif
);
  typedef struct packed {
    logic [cdirq_pkg::NUM_LINES-1:0][cdirq_pkg::CNT_W-1:0] cnt;
    logic [cdirq_pkg::CNT_W-1:0]                           rd_data;
    logic                                                  rd_valid;
  } cdirq_bank_st_type;

  cdirq_bank_st_type st_r;
  cdirq_bank_st_type st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // next state: count each fire, latch the selected count
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rd_valid = cif.rd_en;
    if (cif.rd_en) begin
      st_nxt.rd_data = st_r.cnt[cif.rd_sel];
    end
    for (int i = 0; i < cdirq_pkg::NUM_LINES; i++) begin
      if (cif.inc[i]) begin
        st_nxt.cnt[i] = st_r.cnt[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cif.rd_data  = st_r.rd_data;
  assign cif.rd_valid = st_r.rd_valid;

  ////////////////////////////////////////////////////////////////////////
  chk_count_read: assert property (@(posedge clk) disable iff (!rst_n)
    cif.rd_en |=> (cif.rd_valid && cif.rd_data == $past(st_r.cnt[cif.rd_sel])))
    else $error("fire count read returned wrong value");

  chk_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    cif.inc[3] |=> (st_r.cnt[3] == $past(st_r.cnt[3]) + 16'h0001))
    else $error("fire count did not advance by one");
endmodule : cdirq_cnt_bank

//--- cdirq_top.sv
// Purpose: twelve shared chain interrupt lines, pin direction and reference clock select
// Assumes: 20 MHz REF_CLK; pins and chain lines are asynchronous to it
// Notes:   config errors leave state untouched; line and pin drives hold each level one microsecond
`timescale 1ns/1ps
// Notes on behaviour
// - twelve independently configured chain lines
// - every card sees the same line event
// - line source: rtc, pulse, pin, gps, irig, none
// - source none: never drive, no detection
// - reset leaves lines unsourced and unarmed
// - source first, then edge or level mode
// - host interrupt only when armed and enabled
// - software request fires line without source event
// - per-line fire counter readable by host
// - external reference may replace internal crystal
// - reference pin must be an input
// - per-pin direction and termination
// - reset: pins 0-5 out, 6-11 in, unterminated
// - inputs source only, outputs driven only
// - pin looping onto itself is rejected
// - driven levels hold at least one microsecond
module cdirq_top (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // chain lines
  input  wire logic [11:0] CHAIN_IRQ_LINE_I,
  output logic      [11:0] CHAIN_IRQ_LINE_O,
  output logic      [11:0] CHAIN_IRQ_LINE_OE_N,
  // external pins
  input  wire logic [11:0] EXT_PIN_I,
  output logic      [11:0] EXT_PIN_O,
  output logic      [11:0] EXT_PIN_OE_N,
  output logic      [11:0] EXT_PIN_TERM,
  // local sources
  input  wire logic [7:0]  RTC_TIMER,
  input  wire logic [11:0] SW_PULSE,
  input  wire logic        GPS_PPS,
  input  wire logic        IRIG_PPS,
  // configuration
  input  wire logic        CFG_WR,
  input  wire logic [2:0]  CFG_CMD,
  input  wire logic [3:0]  CFG_TARGET,
  input  wire logic [2:0]  CFG_KIND,
  input  wire logic [3:0]  CFG_INDEX,
  input  wire logic [1:0]  CFG_FLAGS,
  output logic             CFG_ACK,
  output logic             CFG_ERR,
  // line commands and host interrupts
  input  wire logic        LINE_CMD_WR,
  input  wire logic [2:0]  LINE_CMD,
  input  wire logic [3:0]  LINE_CMD_IDX,
  output logic      [11:0] HOST_IRQ,
  output logic      [11:0] LINE_ARMED,
  output logic      [11:0] LINE_ENABLED,
  // fire counts
  input  wire logic        FIRE_COUNT_QUERY,
  input  wire logic [3:0]  FIRE_COUNT_SEL,
  output logic      [15:0] FIRE_COUNT,
  output logic             FIRE_COUNT_VALID,
  // timebase select
  output logic             TIMEBASE_EXT,
  output logic      [3:0]  TIMEBASE_PIN
);
  localparam int NL = cdirq_pkg::NUM_LINES;
  localparam int NP = cdirq_pkg::NUM_PINS;
  localparam int NO = NL + NP;

  typedef struct packed {
    logic [NL-1:0][2:0]  src_kind;
    logic [NL-1:0][3:0]  src_idx;
    logic [NL-1:0][1:0]  mode;
    logic [NL-1:0]       armed;
    logic [NL-1:0]       enabled;
    logic [NP-1:0]       pin_out;
    logic [NP-1:0]       pin_term;
    logic [NP-1:0][2:0]  pin_kind;
    logic [NP-1:0][3:0]  pin_idx;
    logic                ref_ext;
    logic [3:0]          ref_pin;
    logic [NL-1:0]       ci_s1;
    logic [NL-1:0]       ci_s2;
    logic [NL-1:0]       ci_s3;
    logic [NL-1:0]       ci_lvl;
    logic [NP-1:0]       pi_s1;
    logic [NP-1:0]       pi_s2;
    logic [NP-1:0]       pi_s3;
    logic [NP-1:0]       pi_lvl;
    logic [NO-1:0]       drv;
    logic [NO-1:0][4:0]  hold;
    logic [NL-1:0]       line_oe_n;
    logic [NP-1:0]       pin_oe_n;
    logic [NL-1:0]       host_irq;
    logic                cfg_ack;
    logic                cfg_err;
  } cdirq_top_st_type;

  cdirq_top_st_type st_r;
  cdirq_top_st_type st_nxt;
  logic [NL-1:0]    inc_c;
  logic [NO-1:0]    busy_c;

  cdirq_cnt_if cnt_if ();

  ////////////////////////////////////////////////////////////////////////
  // level of a selected source; pins count only while inputs
  function automatic logic cdirq_src_lvl(input logic [2:0] k, input logic [3:0] i,
                                         input logic [NL-1:0] lines,
                                         input logic [NP-1:0] pins);
    logic v;
    v = 1'b0;
    case (k)
      cdirq_pkg::SRC_RTC:   v = RTC_TIMER[i[2:0]];
      cdirq_pkg::SRC_PIG:   v = SW_PULSE[i];
      cdirq_pkg::SRC_INPUT: v = pins[i];
      cdirq_pkg::SRC_GPS:   v = GPS_PPS;
      cdirq_pkg::SRC_IRIG:  v = IRIG_PPS;
      cdirq_pkg::SRC_LINE:  v = lines[i];
      default:              v = 1'b0;
    endcase
    return v;
  endfunction : cdirq_src_lvl

  // index in range for the chosen kind
  function automatic logic cdirq_idx_ok(input logic [2:0] k, input logic [3:0] i);
    return (k == cdirq_pkg::SRC_RTC) ? (int'(i) < cdirq_pkg::NUM_RTC) : (int'(i) < NL);
  endfunction : cdirq_idx_ok

  ////////////////////////////////////////////////////////////////////////
  // config, commands, detection and output drive
  always_comb begin
    logic [NL-1:0] new_ci;
    logic [NP-1:0] new_pi;
    logic [NP-1:0] pin_src;
    logic [NO-1:0] want;
    logic          bad;
    int            t;
    st_nxt  = st_r;
    inc_c   = '0;
    busy_c  = '0;
    new_ci  = '0;
    new_pi  = '0;
    pin_src = '0;
    want    = '0;
    bad     = 1'b0;
    t       = int'(CFG_TARGET);
    st_nxt.cfg_ack = 1'b0;
    st_nxt.cfg_err = 1'b0;
    st_nxt.host_irq = '0;

    // configuration write; rejected writes change nothing
    if (CFG_WR) begin
      if (t >= NL) begin
        bad = 1'b1;
      end else begin
        case (CFG_CMD)
          cdirq_pkg::CFG_LINE_SRC: begin
            bad = (CFG_KIND > cdirq_pkg::SRC_IRIG) || !cdirq_idx_ok(CFG_KIND, CFG_INDEX);
            if (!bad) begin
              st_nxt.src_kind[t] = CFG_KIND;
              st_nxt.src_idx[t]  = CFG_INDEX;
            end
          end
          cdirq_pkg::CFG_LINE_MODE: begin
            bad = (st_r.src_kind[t] == cdirq_pkg::SRC_NONE);
            if (!bad) begin
              st_nxt.mode[t] = CFG_FLAGS;
            end
          end
          cdirq_pkg::CFG_PIN_SET: begin
            bad = CFG_FLAGS[cdirq_pkg::FLG_OUT] && st_r.ref_ext
                  && (st_r.ref_pin == CFG_TARGET);
            if (!bad) begin
              st_nxt.pin_out[t]  = CFG_FLAGS[cdirq_pkg::FLG_OUT];
              st_nxt.pin_term[t] = CFG_FLAGS[cdirq_pkg::FLG_TERM];
            end
          end
          cdirq_pkg::CFG_PIN_SRC: begin
            bad = (CFG_KIND > cdirq_pkg::SRC_LINE) || !cdirq_idx_ok(CFG_KIND, CFG_INDEX)
                  || ((CFG_KIND == cdirq_pkg::SRC_INPUT) && (CFG_INDEX == CFG_TARGET));
            if (!bad) begin
              st_nxt.pin_kind[t] = CFG_KIND;
              st_nxt.pin_idx[t]  = CFG_INDEX;
            end
          end
          cdirq_pkg::CFG_REFCLK: begin
            bad = CFG_FLAGS[cdirq_pkg::FLG_EXT] && st_r.pin_out[t];
            if (!bad) begin
              st_nxt.ref_ext = CFG_FLAGS[cdirq_pkg::FLG_EXT];
              st_nxt.ref_pin = CFG_TARGET;
            end
          end
          default: bad = 1'b1;
        endcase
      end
      st_nxt.cfg_ack = !bad;
      st_nxt.cfg_err = bad;
    end

    // arm, disarm, enable, disable per line
    if (LINE_CMD_WR && (int'(LINE_CMD_IDX) < NL)) begin
      case (LINE_CMD)
        cdirq_pkg::CMD_ARM:     st_nxt.armed[LINE_CMD_IDX]   = 1'b1;
        cdirq_pkg::CMD_DISARM:  st_nxt.armed[LINE_CMD_IDX]   = 1'b0;
        cdirq_pkg::CMD_ENABLE:  st_nxt.enabled[LINE_CMD_IDX] = 1'b1;
        cdirq_pkg::CMD_DISABLE: st_nxt.enabled[LINE_CMD_IDX] = 1'b0;
        default:                st_nxt.armed = st_nxt.armed;
      endcase
    end

    // three-stage capture; a level counts once stages two and three agree
    st_nxt.ci_s1 = CHAIN_IRQ_LINE_I;
    st_nxt.ci_s2 = st_r.ci_s1;
    st_nxt.ci_s3 = st_r.ci_s2;
    st_nxt.pi_s1 = EXT_PIN_I;
    st_nxt.pi_s2 = st_r.pi_s1;
    st_nxt.pi_s3 = st_r.pi_s2;
    new_ci = (st_r.ci_s2 & st_r.ci_s3) | (st_r.ci_lvl & (st_r.ci_s2 ^ st_r.ci_s3));
    new_pi = (st_r.pi_s2 & st_r.pi_s3) | (st_r.pi_lvl & (st_r.pi_s2 ^ st_r.pi_s3));
    st_nxt.ci_lvl = new_ci;
    st_nxt.pi_lvl = new_pi;
    pin_src = st_r.pi_lvl & ~st_r.pin_out;

    // detection on the observed wire, so our own drive is seen like a peer's
    for (int i = 0; i < NL; i++) begin
      logic fire;
      logic held;
      fire = 1'b0;
      held = 1'b0;
      case (st_r.mode[i])
        cdirq_pkg::MODE_RISE: fire = new_ci[i] & ~st_r.ci_lvl[i];
        cdirq_pkg::MODE_FALL: fire = ~new_ci[i] & st_r.ci_lvl[i];
        cdirq_pkg::MODE_HIGH: begin
          fire = new_ci[i] & ~st_r.ci_lvl[i];
          held = new_ci[i];
        end
        default: begin
          fire = ~new_ci[i] & st_r.ci_lvl[i];
          held = ~new_ci[i];
        end
      endcase
      if (st_r.src_kind[i] == cdirq_pkg::SRC_NONE) begin
        fire = 1'b0; // no detection before a source is given
        held = 1'b0;
      end
      if (LINE_CMD_WR && (LINE_CMD == cdirq_pkg::CMD_REQUEST) && (int'(LINE_CMD_IDX) == i)) begin
        fire = 1'b1;
      end
      st_nxt.host_irq[i] = (fire | held) & st_r.armed[i] & st_r.enabled[i];
      inc_c[i] = fire & st_r.armed[i] & st_r.enabled[i];
      want[i]  = cdirq_src_lvl(st_r.src_kind[i], st_r.src_idx[i], st_r.ci_lvl, pin_src);
      st_nxt.line_oe_n[i] = (st_nxt.src_kind[i] == cdirq_pkg::SRC_NONE);
    end
    for (int p = 0; p < NP; p++) begin
      want[NL+p] = cdirq_src_lvl(st_r.pin_kind[p], st_r.pin_idx[p], st_r.ci_lvl, pin_src);
      st_nxt.pin_oe_n[p] = ~st_nxt.pin_out[p];
    end

    // each driven level stands a full microsecond; short pulses within it are lost
    for (int o = 0; o < NO; o++) begin
      busy_c[o] = (st_r.hold[o] != '0);
      if (busy_c[o]) begin
        st_nxt.hold[o] = st_r.hold[o] - 5'h01;
      end else if (want[o] != st_r.drv[o]) begin
        st_nxt.drv[o]  = want[o];
        st_nxt.hold[o] = cdirq_pkg::HOLD_LOAD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset clears lines and sets default pin directions
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      st_r           <= '0;
      st_r.pin_out   <= cdirq_pkg::PIN_DIR_RST;
      st_r.pin_oe_n  <= ~cdirq_pkg::PIN_DIR_RST;
      st_r.line_oe_n <= '1;
      for (int p = 0; p < NP; p++) begin
        st_r.pin_kind[p] <= cdirq_pkg::SRC_PIG;
        st_r.pin_idx[p]  <= 4'(p);
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fire counters
  assign cnt_if.inc    = inc_c;
  assign cnt_if.rd_en  = FIRE_COUNT_QUERY;
  assign cnt_if.rd_sel = FIRE_COUNT_SEL;

  cdirq_cnt_bank u_cnt (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .cif   (cnt_if)
  );

  // outputs straight from registers
  assign CHAIN_IRQ_LINE_O    = st_r.drv[NL-1:0];
  assign CHAIN_IRQ_LINE_OE_N = st_r.line_oe_n;
  assign EXT_PIN_O           = st_r.drv[NO-1:NL];
  assign EXT_PIN_OE_N        = st_r.pin_oe_n;
  assign EXT_PIN_TERM        = st_r.pin_term;
  assign CFG_ACK             = st_r.cfg_ack;
  assign CFG_ERR             = st_r.cfg_err;
  assign HOST_IRQ            = st_r.host_irq;
  assign LINE_ARMED          = st_r.armed;
  assign LINE_ENABLED        = st_r.enabled;
  assign FIRE_COUNT          = cnt_if.rd_data;
  assign FIRE_COUNT_VALID    = cnt_if.rd_valid;
  assign TIMEBASE_EXT        = st_r.ref_ext;
  assign TIMEBASE_PIN        = st_r.ref_pin;

  ////////////////////////////////////////////////////////////////////////
  chk_none_nodrive: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CHAIN_IRQ_LINE_OE_N | {st_r.src_kind[11] != 3'h0, st_r.src_kind[10] != 3'h0,
      st_r.src_kind[9] != 3'h0, st_r.src_kind[8] != 3'h0, st_r.src_kind[7] != 3'h0,
      st_r.src_kind[6] != 3'h0, st_r.src_kind[5] != 3'h0, st_r.src_kind[4] != 3'h0,
      st_r.src_kind[3] != 3'h0, st_r.src_kind[2] != 3'h0, st_r.src_kind[1] != 3'h0,
      st_r.src_kind[0] != 3'h0}) == 12'hFFF)
    else $error("unsourced chain line is being driven");

  chk_irq_gated: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (HOST_IRQ & ~($past(st_r.armed) & $past(st_r.enabled))) == 12'h000)
    else $error("host interrupt while not armed and enabled");

  chk_reset_lines: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(!RST_N) |-> (st_r.src_kind == '0 && LINE_ARMED == 12'h000 && LINE_ENABLED == 12'h000))
    else $error("chain line configured after reset");

  chk_reset_pins: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(!RST_N) |-> (EXT_PIN_OE_N == 12'hFC0 && EXT_PIN_TERM == 12'h000))
    else $error("pin defaults wrong after reset");

  chk_loop_reject: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CFG_WR && CFG_CMD == 3'h3 && CFG_KIND == 3'h3 && CFG_INDEX == CFG_TARGET)
    |=> (CFG_ERR && !CFG_ACK && $stable(st_r.pin_kind) && $stable(st_r.pin_idx)))
    else $error("pin looped onto itself was accepted");

  chk_pin_dir: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    EXT_PIN_OE_N == ~st_r.pin_out)
    else $error("pin driven while configured as input");

  chk_hold_min: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ((st_r.drv ^ $past(st_r.drv)) & $past(busy_c)) == '0)
    else $error("driven level changed before one microsecond");

  chk_sw_request: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (LINE_CMD_WR && LINE_CMD == 3'h4 && LINE_CMD_IDX < 4'hC
      && st_r.armed[LINE_CMD_IDX] && st_r.enabled[LINE_CMD_IDX])
    |=> HOST_IRQ[$past(LINE_CMD_IDX)])
    else $error("software request raised no interrupt");

  chk_ref_input: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    TIMEBASE_EXT |-> !st_r.pin_out[TIMEBASE_PIN])
    else $error("reference clock pin is an output");
endmodule : cdirq_top

//--- cdirq_peer.sv
// Purpose: peer card on the chain driving the shared interrupt lines
// Assumes: chain lines are wired-or with a pull-down; 0 means released
// Notes:   a requested change waits until the previous level has been held long enough
`timescale 1ns/1ps
module cdirq_peer (
  // clock
  input  wire logic        clk,
  // requested and driven levels
  input  wire logic [11:0] want,
  output logic      [11:0] drv
);
  logic [11:0] drv_r  = 12'h000;
  logic [4:0]  hold_r = 5'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // one hold counter for all lines; slower than needed, but never too fast
  always @(posedge clk) begin
    if (hold_r != 5'h00) begin
      hold_r <= hold_r - 5'h01;
    end else if (want != drv_r) begin
      drv_r  <= want;
      hold_r <= cdirq_pkg::HOLD_LOAD;
    end
  end

  assign drv = drv_r;
endmodule : cdirq_peer

//--- cdirq_top_tb.sv
// Purpose: self-checking bench for the chain interrupt and pin setup block
// Assumes: inputs change on the falling edge; one peer card shares the chain
// Notes:   wire levels are resolved here from the block's enables and the peer's drive
`timescale 1ns/1ps
module cdirq_top_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [11:0] peer_want = 12'h000;
  logic [11:0] pin_drv   = 12'h000;
  logic [11:0] sw_pulse  = 12'h000;
  logic [11:0] peer_drv, ch_o, ch_oe_n, ch_wire, pin_o, pin_oe_n, pin_term, pin_wire;
  logic [11:0] host_irq, armed, enabled;
  logic [7:0]  rtc = 8'h00;
  logic        gps = 1'b0;
  logic        irig = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [2:0]  cfg_cmd = 3'h0;
  logic [2:0]  cfg_kind = 3'h0;
  logic [3:0]  cfg_tgt = 4'h0;
  logic [3:0]  cfg_idx = 4'h0;
  logic [1:0]  cfg_flg = 2'h0;
  logic        lc_wr = 1'b0;
  logic [2:0]  lc_cmd = 3'h0;
  logic [3:0]  lc_idx = 4'h0;
  logic        fq = 1'b0;
  logic [3:0]  fq_sel = 4'h0;
  logic        cfg_ack, cfg_err, fq_valid, tb_ext;
  logic [15:0] fq_cnt;
  logic [3:0]  tb_pin;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc;

  ////////////////////////////////////////////////////////////////////////////////
  // wired-or chain with pull-down; a pin is ours only while its enable is low
  assign ch_wire  = peer_drv | (ch_o & ~ch_oe_n);
  assign pin_wire = (pin_o & ~pin_oe_n) | (pin_drv & pin_oe_n);
  always #25 ref_clk = ~ref_clk;

  cdirq_peer i_cdirq_peer (.clk(ref_clk), .want(peer_want), .drv(peer_drv));

  cdirq_top i_cdirq_top (
    .REF_CLK(ref_clk), .RST_N(rst_n), .CHAIN_IRQ_LINE_I(ch_wire), .CHAIN_IRQ_LINE_O(ch_o),
    .CHAIN_IRQ_LINE_OE_N(ch_oe_n), .EXT_PIN_I(pin_wire), .EXT_PIN_O(pin_o),
    .EXT_PIN_OE_N(pin_oe_n), .EXT_PIN_TERM(pin_term), .RTC_TIMER(rtc), .SW_PULSE(sw_pulse),
    .GPS_PPS(gps), .IRIG_PPS(irig), .CFG_WR(cfg_wr), .CFG_CMD(cfg_cmd), .CFG_TARGET(cfg_tgt),
    .CFG_KIND(cfg_kind), .CFG_INDEX(cfg_idx), .CFG_FLAGS(cfg_flg), .CFG_ACK(cfg_ack),
    .CFG_ERR(cfg_err), .LINE_CMD_WR(lc_wr), .LINE_CMD(lc_cmd), .LINE_CMD_IDX(lc_idx),
    .HOST_IRQ(host_irq), .LINE_ARMED(armed), .LINE_ENABLED(enabled),
    .FIRE_COUNT_QUERY(fq), .FIRE_COUNT_SEL(fq_sel), .FIRE_COUNT(fq_cnt),
    .FIRE_COUNT_VALID(fq_valid), .TIMEBASE_EXT(tb_ext), .TIMEBASE_PIN(tb_pin));

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // one config write; the answer is looked at in the single cycle it stands
  task automatic cfg(input logic [2:0] cmd, input logic [3:0] tgt, input logic [2:0] kind,
                     input logic [3:0] idx, input logic [1:0] flg, input logic bad);
    @(negedge ref_clk);
    cfg_wr   = 1'b1;
    cfg_cmd  = cmd;
    cfg_tgt  = tgt;
    cfg_kind = kind;
    cfg_idx  = idx;
    cfg_flg  = flg;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    chk("cfg_ack", 16'(cfg_ack), 16'(!bad));
    chk("cfg_err", 16'(cfg_err), 16'(bad));
  endtask : cfg

  task automatic lcmd(input logic [2:0] cmd, input logic [3:0] idx);
    @(negedge ref_clk);
    lc_wr  = 1'b1;
    lc_cmd = cmd;
    lc_idx = idx;
    @(negedge ref_clk);
    lc_wr = 1'b0;
  endtask : lcmd

  // one fire count query, called at a falling edge; valid stands a single cycle
  task automatic fcount(input logic [3:0] sel, input logic [15:0] exp);
    fq     = 1'b1;
    fq_sel = sel;
    @(negedge ref_clk);
    fq = 1'b0;
    chk("count_valid", 16'(fq_valid), 16'h1);
    chk("fire_count", fq_cnt, exp);
  endtask : fcount

  // bounded wait for a host interrupt, counting falling edges
  task automatic wait_irq(input int line, output int n);
    n = 0;
    while (host_irq[line] !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 40) begin
        chk("host_irq_wait", 16'h0, 16'h1);
        results();
      end
    end
  endtask : wait_irq

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_sources();
    for (int k = 5; k >= 0; k--) begin
      cfg(cdirq_pkg::CFG_LINE_SRC, 4'h4, 3'(k), 4'h0, 2'h0, 1'b0);
      chk("line4_oe_n", 16'(ch_oe_n[4]), 16'(k == 0));
    end
    cfg(cdirq_pkg::CFG_LINE_SRC, 4'h4, cdirq_pkg::SRC_LINE, 4'h0, 2'h0, 1'b1);
    cfg(cdirq_pkg::CFG_LINE_SRC, 4'h4, cdirq_pkg::SRC_RTC, 4'h8, 2'h0, 1'b1);
    cfg(cdirq_pkg::CFG_LINE_SRC, 4'hC, cdirq_pkg::SRC_PIG, 4'h0, 2'h0, 1'b1);
    cfg(cdirq_pkg::CFG_LINE_MODE, 4'h5, 3'h0, 4'h0, cdirq_pkg::MODE_RISE, 1'b1);
  endtask : t_sources

  // a one-cycle software pulse must stand on the line for the full hold
  task automatic t_hold();
    cfg(cdirq_pkg::CFG_LINE_SRC, 4'h2, cdirq_pkg::SRC_PIG, 4'h1, 2'h0, 1'b0);
    chk("line2_oe_n", 16'(ch_oe_n[2]), 16'h0);
    sw_pulse[1] = 1'b1;
    @(negedge ref_clk);
    sw_pulse[1] = 1'b0;
    cyc = 0;
    repeat (40) begin
      cyc += int'(ch_o[2] === 1'b1);
      @(negedge ref_clk);
    end
    chk("line2_high_cycles", 16'(cyc), 16'(cdirq_pkg::HOLD_CYC));
    cfg(cdirq_pkg::CFG_LINE_SRC, 4'h2, cdirq_pkg::SRC_NONE, 4'h0, 2'h0, 1'b0);
    chk("line2_oe_n", 16'(ch_oe_n[2]), 16'h1);
  endtask : t_hold

  task automatic t_request();
    lcmd(cdirq_pkg::CMD_ARM, 4'h0);
    chk("armed0", 16'(armed[0]), 16'h1);
    lcmd(cdirq_pkg::CMD_REQUEST, 4'h0);
    chk("irq0_unenabled", 16'(host_irq[0]), 16'h0);
    lcmd(cdirq_pkg::CMD_ENABLE, 4'h0);
    lcmd(cdirq_pkg::CMD_REQUEST, 4'h0);
    chk("irq0_request", 16'(host_irq[0]), 16'h1);
    lcmd(cdirq_pkg::CMD_DISABLE, 4'h0);
    chk("enabled0", 16'(enabled[0]), 16'h0);
    lcmd(cdirq_pkg::CMD_DISARM, 4'h0);
    chk("armed0", 16'(armed[0]), 16'h0);
    fcount(4'h0, 16'h0001);
  endtask : t_request

  // peer toggles line 3 in each trigger mode; edge modes pulse, level modes hold
  // waits before each toggle outlast the peer's hold, so the toggle goes out at once; the return to idle waits out the hold
  task automatic t_modes();
    logic lvl;
    cfg(cdirq_pkg::CFG_LINE_SRC, 4'h3, cdirq_pkg::SRC_RTC, 4'h0, 2'h0, 1'b0);
    lcmd(cdirq_pkg::CMD_ARM, 4'h3);
    lcmd(cdirq_pkg::CMD_ENABLE, 4'h3);
    for (int m = 0; m < 4; m++) begin
      lvl = (m == 1 || m == 3);
      cfg(cdirq_pkg::CFG_LINE_MODE, 4'h3, 3'h0, 4'h0, 2'(m), 1'b0);
      peer_want[3] = lvl;
      repeat (40) @(negedge ref_clk);
      chk("irq3_idle", 16'(host_irq[3]), 16'h0);
      peer_want[3] = !lvl;
      wait_irq(3, cyc);
      chk("irq3_delay", 16'(cyc), 16'h5);
      @(negedge ref_clk);
      chk("irq3_after", 16'(host_irq[3]), 16'(m >= 2));
      peer_want[3] = lvl;
      repeat (40) @(negedge ref_clk);
    end
    fcount(4'h3, 16'h0004);
  endtask : t_modes

  task automatic t_pins();
    cfg(cdirq_pkg::CFG_PIN_SET, 4'h7, 3'h0, 4'h0, 2'h3, 1'b0);
    chk("pin7_dir_term", 16'({pin_oe_n[7], pin_term[7]}), 16'h1);
    cfg(cdirq_pkg::CFG_PIN_SRC, 4'h0, cdirq_pkg::SRC_INPUT, 4'h0, 2'h0, 1'b1);
    cfg(cdirq_pkg::CFG_PIN_SRC, 4'h0, cdirq_pkg::SRC_INPUT, 4'h8, 2'h0, 1'b0);
    pin_drv[8] = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("pin0_follows_pin8", 16'(pin_o[0]), 16'h1);
    cfg(cdirq_pkg::CFG_REFCLK, 4'h0, 3'h0, 4'h0, 2'h1, 1'b1);
    cfg(cdirq_pkg::CFG_REFCLK, 4'h9, 3'h0, 4'h0, 2'h1, 1'b0);
    chk("timebase", 16'({tb_ext, tb_pin}), 16'h19);
    cfg(cdirq_pkg::CFG_PIN_SET, 4'h9, 3'h0, 4'h0, 2'h1, 1'b1);
  endtask : t_pins

  ////////////////////////////////////////////////////////////////////////////////
  // reset for 12 cycles, then the main defaults; used at start and again at the end
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("chain_oe_n", 16'(ch_oe_n), 16'h0FFF);
    chk("pin_oe_n", 16'(pin_oe_n), 16'h0FC0);
    chk("pin_term", 16'(pin_term), 16'h0000);
    chk("armed", 16'(armed), 16'h0000);
    chk("enabled", 16'(enabled), 16'h0000);
    chk("host_irq", 16'(host_irq), 16'h0000);
    chk("timebase_ext", 16'(tb_ext), 16'h0);
    fcount(4'h3, 16'h0000);
  endtask : t_reset

  // main sequence
  initial begin
    t_reset();
    t_sources();
    t_hold();
    t_request();
    t_modes();
    t_pins();
    t_reset();
    results();
  end
endmodule : cdirq_top_tb
